// *** src/trdc_avg.sv ***
// Sixteen-sample averager for one temperature channel
module trdc_avg #(
   parameter int W = 10,
   parameter int SHIFT = 4
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic [W-1:0] sample_i,
   input wire logic strobe_i,
   input wire logic avg_en_i,
   input wire logic restart_i,
   output logic [W-1:0] result_o,
   output logic update_o
);

   logic [W+SHIFT-1:0] acc_q;
   logic [W+SHIFT-1:0] sum;
   logic [SHIFT-1:0] cnt_q;
   logic last;

   ////////////////////////////////////////////////////////////////////////
   // Sign-extended running sum and last-sample detect
   assign sum = acc_q + {{SHIFT{sample_i[W-1]}}, sample_i};
   assign last = (cnt_q == {SHIFT{1'b1}});

   // Accumulator; a restart discards a partial average
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         acc_q <= '0;
         cnt_q <= '0;
      end
      else if (restart_i || !avg_en_i)
      begin
         acc_q <= '0;
         cnt_q <= '0;
      end
      else if (strobe_i)
      begin
         acc_q <= last ? '0 : sum; // [R7]
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // Result and one-cycle update pulse; value held otherwise
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         result_o <= '0;
         update_o <= 1'b0;
      end
      else
      begin
         update_o <= 1'b0;
         if (strobe_i && !avg_en_i)
         begin
            result_o <= sample_i; // [R6] [R10]
            update_o <= 1'b1;
         end
         else if (strobe_i && !restart_i && last)
         begin
            result_o <= sum[W+SHIFT-1:SHIFT]; // [R7]
            update_o <= 1'b1;
         end
      end
   end

endmodule

// *** src/trdc_cfg.svh ***
// Register offsets, reset values, field positions and masks of the block
`ifndef TRDC_CFG_SVH
`define TRDC_CFG_SVH

// Register offsets on the serial register port
`define TRDC_OFF_CFG        8'h03
`define TRDC_OFF_RATE       8'h04
`define TRDC_OFF_DAC_EN     8'h0C
`define TRDC_OFF_TEMP_LOC   8'h0E
`define TRDC_OFF_TEMP_REM   8'h0F
`define TRDC_OFF_ADC_FIRST  8'h1A
`define TRDC_OFF_ADC_LAST   8'h29
`define TRDC_OFF_DAC_FIRST  8'h2A
`define TRDC_OFF_DAC_LAST   8'h35
`define TRDC_OFF_LIM_LOC_HI 8'h56
`define TRDC_OFF_LIM_LOC_LO 8'h57
`define TRDC_OFF_LIM_REM_HI 8'h58
`define TRDC_OFF_LIM_REM_LO 8'h59

// Reset values
`define TRDC_CFG_RST        16'h0000
`define TRDC_RATE_RST       16'h0006
`define TRDC_DAC_EN_RST     12'hFFF
`define TRDC_LIM_HI_RST     10'h1F4
`define TRDC_LIM_LO_RST     10'h324
`define TRDC_RD_ZERO        16'h0000

// Field positions
`define TRDC_CFG_MON_BIT    0
`define TRDC_CFG_RANGE_BIT  7
`define TRDC_RATE_MSB       3
`define TRDC_RATE_LSB       0
`define TRDC_RATE_AVG_BIT   4
`define TRDC_RATE_MAX_AVG   4'h5

// Channel groupings, bit n stands for output n+1
`define TRDC_DUAL_RANGE_MASK 12'hC30
`define TRDC_BANK1_MASK      12'h03F

`endif

// *** src/trdc_pkg.sv ***
// Types shared by the temperature result and DAC control block
package trdc_pkg;

   // Register port request from the serial interface
   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } trdc_reg_req_t;

   // Register port answer
   typedef struct packed {
      logic [15:0] rdata;
      logic ack;
   } trdc_reg_rsp_t;

   // One temperature round-robin result pair
   typedef struct packed {
      logic [9:0] local_val;
      logic [9:0] remote_val;
      logic done;
   } trdc_temp_smp_t;

   // One voltage conversion result
   typedef struct packed {
      logic [9:0] code;
      logic [3:0] chan;
      logic valid;
   } trdc_adc_smp_t;

   // Conversion rate codes
   typedef enum logic [3:0] {
      TRDC_RATE_1_16 = 4'b0000,
      TRDC_RATE_1_8  = 4'b0001,
      TRDC_RATE_1_4  = 4'b0010,
      TRDC_RATE_1_2  = 4'b0011,
      TRDC_RATE_1    = 4'b0100,
      TRDC_RATE_2    = 4'b0101,
      TRDC_RATE_4    = 4'b0110,
      TRDC_RATE_8    = 4'b0111,
      TRDC_RATE_16   = 4'b1000,
      TRDC_RATE_32   = 4'b1001
   } trdc_rate_t;

endpackage

// *** src/trdc_top.sv ***
// Temperature results, voltage results and DAC control register block
//
// Contract
// [R1] Temperature results are 10-bit two's complement, LSB a quarter degree.
// [R2] High and low temperature limits are two's complement and compared.
// [R3] Local temperature sits at offset 0x0E, remote at 0x0F.
// [R4] Upper eight bits whole degrees, lower two quarter fraction, -55..125.
// [R5] Each analog input reads as unsigned 10-bit code over 2.5 V.
// [R6] Without averaging, results refresh once per temperature cycle.
// [R7] With averaging, results refresh after 16 cycles with their mean.
// [R8] Previous temperature stays until a new valid result exists.
// [R9] Averaging permitted only at rates 1/16 up to 2 per second.
// [R10] At 4, 8, 16, 32 per second no averaging, update every cycle.
// [R11] Host halts monitoring or drops first reading around averaging change.
// [R12] Twelve DAC code registers at 0x2A to 0x35, 12 bits each.
// [R13] Codes 0 to 4095 map linearly, 4095 is full scale 5 V or 12 V.
// [R14] Every DAC output is 0 V after power-up until programmed.
// [R15] Outputs 1-4, 7-10 fixed 5 V; outputs 5-6, 11-12 dual range.
// [R16] Bit 7 of register 0x03 selects dual range; default all 5 V.
// [R17] Low bank shutdown input grounds that bank's outputs.
// [R18] Shutdown or channel clear leaves DAC codes untouched.
// [R19] Register 0x0C holds per-DAC enables, reset enabled, 0 grounds.
// [R20] Out of limit means strictly above high or strictly below low.
// [R21] Outputs 1-6 belong to bank one, outputs 7-12 to bank two.
`include "trdc_cfg.svh"

module trdc_top #(
   parameter int NDAC = 12,
   parameter int DW = 12,
   parameter int TW = 10,
   parameter int AW = 10,
   parameter int NADC = 16,
   parameter int AVG_SHIFT = 4
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire trdc_pkg::trdc_reg_req_t reg_req_i,
   input wire trdc_pkg::trdc_temp_smp_t temp_i,
   input wire trdc_pkg::trdc_adc_smp_t adc_i,
   input wire logic first_bank_output_kill_n_i,
   input wire logic second_bank_output_kill_n_i,
   output trdc_pkg::trdc_reg_rsp_t reg_rsp_o,
   output logic [NDAC-1:0][DW-1:0] output_code_word_o,
   output logic [NDAC-1:0] dac_connect_o,
   output logic [NDAC-1:0] dac_range_high_o,
   output logic [1:0] temp_over_high_o,
   output logic [1:0] temp_under_low_o,
   output logic monitor_en_o
);

   ////////////////////////////////////////////////////////////////////////
   // Functions

   // Strict signed comparison against a limit pair
   function automatic logic [1:0] lim_check(
      input logic [TW-1:0] val,
      input logic [TW-1:0] hi,
      input logic [TW-1:0] lo
   );
      logic [1:0] r;
      r = 2'b00;
      r[1] = $signed(val) > $signed(hi); // [R20] [R2]
      r[0] = $signed(val) < $signed(lo); // [R20] [R2]
      return r;
   endfunction

   // Averaging is allowed only at the slow rate codes
   function automatic logic rate_avg_ok(input logic [3:0] code);
      return code <= `TRDC_RATE_MAX_AVG; // [R9] [R10]
   endfunction

   // Zero-extend a narrow field onto the 16-bit read bus
   function automatic logic [15:0] ext16(input logic [11:0] v, input int w);
      logic [15:0] r;
      r = '0;
      for (int i = 0; i < 12; i++)
      begin
         if (i < w)
         begin
            r[i] = v[i];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [15:0] cfg_q;
   logic [15:0] rate_q;
   logic [NDAC-1:0] dac_en_q;
   logic [NDAC-1:0][DW-1:0] dac_q;
   logic [AW-1:0] adc_q [NADC];
   logic [TW-1:0] loc_val_q;
   logic [TW-1:0] rem_val_q;
   logic [TW-1:0] lim_loc_hi_q;
   logic [TW-1:0] lim_loc_lo_q;
   logic [TW-1:0] lim_rem_hi_q;
   logic [TW-1:0] lim_rem_lo_q;
   logic avg_eff_q;
   logic avg_eff_d;
   logic mon_en;
   logic restart;
   logic strobe;
   logic [TW-1:0] loc_res;
   logic [TW-1:0] rem_res;
   logic loc_upd;
   logic rem_upd;
   logic [7:0] dac_idx;
   logic [7:0] adc_idx;
   logic in_dac;
   logic in_adc;
   logic [15:0] rd_mux;
   logic [NDAC-1:0] bank_ok;
   logic [1:0] loc_lim;
   logic [1:0] rem_lim;

   ////////////////////////////////////////////////////////////////////////
   // Address decode helpers

   // Window decodes for the register arrays
   assign in_dac = (reg_req_i.addr >= `TRDC_OFF_DAC_FIRST) &&
                   (reg_req_i.addr <= `TRDC_OFF_DAC_LAST); // [R12]
   assign in_adc = (reg_req_i.addr >= `TRDC_OFF_ADC_FIRST) &&
                   (reg_req_i.addr <= `TRDC_OFF_ADC_LAST);
   assign dac_idx = reg_req_i.addr - `TRDC_OFF_DAC_FIRST;
   assign adc_idx = reg_req_i.addr - `TRDC_OFF_ADC_FIRST;

   ////////////////////////////////////////////////////////////////////////
   // Configuration and rate registers

   // Main configuration register
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cfg_q <= `TRDC_CFG_RST; // [R16]
      end
      else if (reg_req_i.wr && reg_req_i.addr == `TRDC_OFF_CFG)
      begin
         cfg_q <= reg_req_i.wdata;
      end
   end

   // Conversion rate and averaging request register
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rate_q <= `TRDC_RATE_RST;
      end
      else if (reg_req_i.wr && reg_req_i.addr == `TRDC_OFF_RATE)
      begin
         rate_q <= reg_req_i.wdata;
      end
   end

   // Effective averaging: requested and allowed by the rate
   assign mon_en = cfg_q[`TRDC_CFG_MON_BIT];
   assign avg_eff_d = rate_q[`TRDC_RATE_AVG_BIT] &&
      rate_avg_ok(rate_q[`TRDC_RATE_MSB:`TRDC_RATE_LSB]); // [R9] [R10]

   // Registered mode, so a mode change can restart the averagers
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         avg_eff_q <= 1'b0;
      end
      else
      begin
         avg_eff_q <= avg_eff_d;
      end
   end

   // Stopped monitoring or a mode change drops partial averages
   assign restart = !mon_en || (avg_eff_d != avg_eff_q); // [R11]
   assign strobe = temp_i.done && mon_en;

   ////////////////////////////////////////////////////////////////////////
   // Temperature averaging

   // Local channel
   trdc_avg #(
      .W(TW),
      .SHIFT(AVG_SHIFT)
   ) u_avg_loc (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .sample_i(temp_i.local_val),
      .strobe_i(strobe),
      .avg_en_i(avg_eff_q),
      .restart_i(restart),
      .result_o(loc_res),
      .update_o(loc_upd)
   );

   // Remote channel
   trdc_avg #(
      .W(TW),
      .SHIFT(AVG_SHIFT)
   ) u_avg_rem (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .sample_i(temp_i.remote_val),
      .strobe_i(strobe),
      .avg_en_i(avg_eff_q),
      .restart_i(restart),
      .result_o(rem_res),
      .update_o(rem_upd)
   );

   // Temperature value registers, held until a new result
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         loc_val_q <= '0;
         rem_val_q <= '0;
      end
      else
      begin
         if (loc_upd)
         begin
            loc_val_q <= loc_res; // [R1] [R4] [R8]
         end
         if (rem_upd)
         begin
            rem_val_q <= rem_res; // [R1] [R4] [R8]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Temperature limits and comparison

   // Limit registers, two's complement
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         lim_loc_hi_q <= `TRDC_LIM_HI_RST;
         lim_loc_lo_q <= `TRDC_LIM_LO_RST;
         lim_rem_hi_q <= `TRDC_LIM_HI_RST;
         lim_rem_lo_q <= `TRDC_LIM_LO_RST;
      end
      else if (reg_req_i.wr)
      begin
         case (reg_req_i.addr)
            `TRDC_OFF_LIM_LOC_HI: lim_loc_hi_q <= reg_req_i.wdata[TW-1:0];
            `TRDC_OFF_LIM_LOC_LO: lim_loc_lo_q <= reg_req_i.wdata[TW-1:0];
            `TRDC_OFF_LIM_REM_HI: lim_rem_hi_q <= reg_req_i.wdata[TW-1:0];
            `TRDC_OFF_LIM_REM_LO: lim_rem_lo_q <= reg_req_i.wdata[TW-1:0];
            default: ;
         endcase
      end
   end

   // Compare stored results with their limits
   assign loc_lim = lim_check(loc_val_q, lim_loc_hi_q, lim_loc_lo_q); // [R2]
   assign rem_lim = lim_check(rem_val_q, lim_rem_hi_q, lim_rem_lo_q); // [R2]

   // Registered limit flags; bit 0 local, bit 1 remote
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         temp_over_high_o <= 2'b00;
         temp_under_low_o <= 2'b00;
      end
      else
      begin
         temp_over_high_o <= {rem_lim[1], loc_lim[1]}; // [R20]
         temp_under_low_o <= {rem_lim[0], loc_lim[0]}; // [R20]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Voltage result registers

   // Store each conversion at its channel while monitoring runs
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         for (int i = 0; i < NADC; i++)
         begin
            adc_q[i] <= '0;
         end
      end
      else if (adc_i.valid && mon_en)
      begin
         adc_q[adc_i.chan] <= adc_i.code; // [R5]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // DAC registers

   // Code registers; only a write changes them
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         dac_q <= '0; // [R14]
      end
      else if (reg_req_i.wr && in_dac)
      begin
         dac_q[dac_idx[3:0]] <= reg_req_i.wdata[DW-1:0]; // [R12] [R18]
      end
   end

   // Per-channel enable register
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         dac_en_q <= `TRDC_DAC_EN_RST; // [R19]
      end
      else if (reg_req_i.wr && reg_req_i.addr == `TRDC_OFF_DAC_EN)
      begin
         dac_en_q <= reg_req_i.wdata[NDAC-1:0]; // [R19]
      end
   end

   // Bank shutdown pins map onto channel groups
   assign bank_ok = (`TRDC_BANK1_MASK & {NDAC{first_bank_output_kill_n_i}}) |
      (~`TRDC_BANK1_MASK & {NDAC{second_bank_output_kill_n_i}}); // [R21]

   // Output drive: code, connection and range, all registered
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         output_code_word_o <= '0; // [R14]
         dac_connect_o <= '0;
         dac_range_high_o <= '0;
      end
      else
      begin
         output_code_word_o <= dac_q; // [R13] [R18]
         dac_connect_o <= dac_en_q & bank_ok; // [R17] [R19]
         dac_range_high_o <= `TRDC_DUAL_RANGE_MASK &
            {NDAC{cfg_q[`TRDC_CFG_RANGE_BIT]}}; // [R15] [R16]
      end
   end

   // Monitoring enable, registered for the converter sequencers
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         monitor_en_o <= 1'b0;
      end
      else
      begin
         monitor_en_o <= mon_en;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path

   // Read multiplexer; unmapped offsets read zero
   always_comb
   begin
      rd_mux = `TRDC_RD_ZERO;
      if (in_dac)
      begin
         rd_mux = ext16(dac_q[dac_idx[3:0]], DW);
      end
      else if (in_adc)
      begin
         rd_mux = ext16({2'b00, adc_q[adc_idx[3:0]]}, AW);
      end
      else
      begin
         case (reg_req_i.addr)
            `TRDC_OFF_CFG: rd_mux = cfg_q;
            `TRDC_OFF_RATE: rd_mux = rate_q;
            `TRDC_OFF_DAC_EN: rd_mux = ext16(dac_en_q, NDAC);
            `TRDC_OFF_TEMP_LOC: rd_mux = ext16({2'b00, loc_val_q}, TW); // [R3]
            `TRDC_OFF_TEMP_REM: rd_mux = ext16({2'b00, rem_val_q}, TW); // [R3]
            `TRDC_OFF_LIM_LOC_HI: rd_mux = ext16({2'b00, lim_loc_hi_q}, TW);
            `TRDC_OFF_LIM_LOC_LO: rd_mux = ext16({2'b00, lim_loc_lo_q}, TW);
            `TRDC_OFF_LIM_REM_HI: rd_mux = ext16({2'b00, lim_rem_hi_q}, TW);
            `TRDC_OFF_LIM_REM_LO: rd_mux = ext16({2'b00, lim_rem_lo_q}, TW);
            default: rd_mux = `TRDC_RD_ZERO;
         endcase
      end
   end

   // Answer one cycle after a read or write request
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         reg_rsp_o <= '0;
      end
      else
      begin
         reg_rsp_o.ack <= reg_req_i.rd || reg_req_i.wr;
         if (reg_req_i.rd)
         begin
            reg_rsp_o.rdata <= rd_mux;
         end
      end
   end

endmodule

// *** tb/trdc_host_model.sv ***
// Host controller model: register port master and bank shutdown pins
module trdc_host_model (
   input wire logic clk_sys_i,
   input wire trdc_pkg::trdc_reg_rsp_t reg_rsp_i,
   output trdc_pkg::trdc_reg_req_t reg_req_o,
   output logic first_bank_output_kill_n_o,
   output logic second_bank_output_kill_n_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus, both banks running
   initial
   begin
      reg_req_o = '0;
      first_bank_output_kill_n_o = 1'b1;
      second_bank_output_kill_n_o = 1'b1;
   end

   // One access: single cycle strobe, answer taken one edge after
   task automatic access(input logic [7:0] a, input logic [15:0] d,
      input logic w, output logic [15:0] q, output logic k);
      @(posedge clk_sys_i);
      reg_req_o <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge clk_sys_i);
      reg_req_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
      @(posedge clk_sys_i);
      q = reg_rsp_i.rdata;
      k = reg_rsp_i.ack;
   endtask

   // Drive both shutdown pins
   task automatic bank(input logic b1, input logic b2);
      @(posedge clk_sys_i);
      first_bank_output_kill_n_o <= b1;
      second_bank_output_kill_n_o <= b2;
   endtask

   // Averaging change wrapped in a monitoring stop and restart
   task automatic change_rate(input logic [15:0] rate, input logic [15:0] cfg);
      logic [15:0] q;
      logic k;
      access(8'h03, cfg & 16'hFFFE, 1'b1, q, k);
      access(8'h04, rate, 1'b1, q, k);
      access(8'h03, cfg, 1'b1, q, k);
   endtask
endmodule

// *** tb/trdc_properties.sv ***
// Port checker for the temperature result and DAC control block
`include "trdc_cfg.svh"

module trdc_properties #(
   parameter int NDAC = 12,
   parameter int DW = 12
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire trdc_pkg::trdc_reg_req_t reg_req_i,
   input wire logic first_bank_output_kill_n_i,
   input wire logic second_bank_output_kill_n_i,
   input wire trdc_pkg::trdc_reg_rsp_t reg_rsp_o,
   input wire logic [NDAC-1:0][DW-1:0] output_code_word_o,
   input wire logic [NDAC-1:0] dac_connect_o,
   input wire logic [NDAC-1:0] dac_range_high_o,
   input wire logic monitor_en_o
);
   logic req;
   logic dac_wr;
   logic banks_up;
   logic [3:0] dac_idx;

   ////////////////////////////////////////////////////////////////////////
   // Request decoding
   assign req = reg_req_i.rd || reg_req_i.wr;
   assign dac_wr = reg_req_i.wr && (reg_req_i.addr >= `TRDC_OFF_DAC_FIRST)
      && (reg_req_i.addr <= `TRDC_OFF_DAC_LAST);
   assign dac_idx = 4'(reg_req_i.addr - `TRDC_OFF_DAC_FIRST);
   assign banks_up = first_bank_output_kill_n_i && second_bank_output_kill_n_i;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!nrst_i);

   ////////////////////////////////////////////////////////////////////////
   // Properties
   property p_ack;
      req |=> reg_rsp_o.ack;
   endproperty
   property p_no_ack;
      !req |=> !reg_rsp_o.ack;
   endproperty
   property p_range_set;
      dac_range_high_o == 12'h000 || dac_range_high_o == 12'hC30;
   endproperty
   property p_cfg_upd;
      reg_req_i.wr && reg_req_i.addr == 8'h03 |-> ##2
         dac_range_high_o == ($past(reg_req_i.wdata[7], 2) ? 12'hC30 : 12'h000)
         && monitor_en_o == $past(reg_req_i.wdata[0], 2);
   endproperty
   property p_bank1;
      !first_bank_output_kill_n_i |=> dac_connect_o[5:0] == 6'h00;
   endproperty
   property p_bank2;
      !second_bank_output_kill_n_i |=> dac_connect_o[11:6] == 6'h00;
   endproperty
   property p_code_hold;
      !dac_wr |-> ##2 $stable(output_code_word_o);
   endproperty
   property p_code_upd;
      dac_wr |-> ##2 output_code_word_o[$past(dac_idx, 2)]
         == $past(reg_req_i.wdata[DW-1:0], 2);
   endproperty
   property p_en_upd;
      reg_req_i.wr && reg_req_i.addr == 8'h0C && banks_up ##1 banks_up
         ##1 banks_up |-> dac_connect_o == $past(reg_req_i.wdata[11:0], 2);
   endproperty

   a_ack: assert property (p_ack)
      else $error("no answer one cycle after a request");
   a_no_ack: assert property (p_no_ack)
      else $error("answer without a request");
   a_range_set: assert property (p_range_set)
      else $error("high range on a fixed range output");
   a_cfg_upd: assert property (p_cfg_upd)
      else $error("range or monitor output not following config write");
   a_bank1: assert property (p_bank1)
      else $error("first bank output left connected");
   a_bank2: assert property (p_bank2)
      else $error("second bank output left connected");
   a_code_hold: assert property (p_code_hold)
      else $error("output code changed without a code write");
   a_code_upd: assert property (p_code_upd)
      else $error("output code not taken from write");
   a_en_upd: assert property (p_en_upd)
      else $error("connect pattern not following enable write");

   c_bank: cover property (!first_bank_output_kill_n_i ##1 1'b1);
   c_range: cover property (dac_range_high_o == 12'hC30);
   c_code: cover property (dac_wr ##2 1'b1);
endmodule

bind trdc_top trdc_properties #(.NDAC(NDAC), .DW(DW)) u_props (
   .clk_sys_i(clk_sys_i),
   .nrst_i(nrst_i),
   .reg_req_i(reg_req_i),
   .first_bank_output_kill_n_i(first_bank_output_kill_n_i),
   .second_bank_output_kill_n_i(second_bank_output_kill_n_i),
   .reg_rsp_o(reg_rsp_o),
   .output_code_word_o(output_code_word_o),
   .dac_connect_o(dac_connect_o),
   .dac_range_high_o(dac_range_high_o),
   .monitor_en_o(monitor_en_o)
);

// *** tb/trdc_tb_top.sv ***
// Self-checking bench for the temperature result and DAC control block
`define CHK(got, exp) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) \
      begin \
         fail_count++; \
         $display("Error at %0t: got %h expected %h", $time, got, exp); \
      end \
   end

module trdc_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_sys;
   logic nrst;
   trdc_pkg::trdc_reg_req_t req;
   trdc_pkg::trdc_reg_rsp_t rsp;
   trdc_pkg::trdc_temp_smp_t temp;
   trdc_pkg::trdc_adc_smp_t adc;
   logic kill1_n;
   logic kill2_n;
   logic [11:0][11:0] code;
   logic [11:0] conn;
   logic [11:0] range_hi;
   logic [1:0] over;
   logic [1:0] under;
   logic mon;
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;
   logic [9:0] prev;

   trdc_top dut (
      .clk_sys_i(clk_sys), .nrst_i(nrst), .reg_req_i(req), .temp_i(temp),
      .adc_i(adc), .first_bank_output_kill_n_i(kill1_n),
      .second_bank_output_kill_n_i(kill2_n), .reg_rsp_o(rsp),
      .output_code_word_o(code), .dac_connect_o(conn),
      .dac_range_high_o(range_hi), .temp_over_high_o(over),
      .temp_under_low_o(under), .monitor_en_o(mon)
   );

   trdc_host_model host (
      .clk_sys_i(clk_sys), .reg_rsp_i(rsp), .reg_req_o(req),
      .first_bank_output_kill_n_o(kill1_n),
      .second_bank_output_kill_n_o(kill2_n)
   );

   ////////////////////////////////////////////////////////////////////////
   // Clock and cycle ceiling
   always #20 clk_sys = ~clk_sys;

   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fail_count++;
         report_and_stop();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Access and stream tasks
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [15:0] q;
      logic k;
      host.access(a, d, 1'b1, q, k);
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] q;
      logic k;
      host.access(a, 16'h0000, 1'b0, q, k);
      `CHK(q, e)
      `CHK(k, 1'b1)
   endtask

   task automatic temp_done(input logic [9:0] l, input logic [9:0] r);
      @(posedge clk_sys);
      temp <= '{local_val: l, remote_val: r, done: 1'b1};
      @(posedge clk_sys);
      temp <= '{local_val: ~l, remote_val: ~r, done: 1'b0};
      repeat (2) @(posedge clk_sys);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      clk_sys = 1'b0;
      nrst = 1'b0;
      temp = '0;
      adc = '0;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      `CHK(code, 144'h0)
      `CHK(conn, 12'hFFF)
      `CHK(range_hi, 12'h000)
      rd(8'h03, 16'h0000);
      rd(8'h0C, 16'h0FFF);
      rd(8'h56, 16'h01F4);
      rd(8'h59, 16'h0324);
      // Every code register, upper bits dropped
      for (int i = 0; i < 12; i++)
         wr(8'(8'h2A + i), {4'hF, 12'(12'hFFF - i)});
      for (int i = 0; i < 12; i++)
      begin
         rd(8'(8'h2A + i), {4'h0, 12'(12'hFFF - i)});
         `CHK(code[i], 12'(12'hFFF - i))
      end
      rd(8'h36, 16'h0000);
      wr(8'h0E, 16'h1234);
      rd(8'h0E, 16'h0000);
      wr(8'h03, 16'h0081);
      rd(8'h03, 16'h0081);
      `CHK(range_hi, 12'hC30)
      // All bank pin combinations
      for (int k = 0; k < 4; k++)
      begin
         host.bank(k[0], k[1]);
         repeat (2) @(posedge clk_sys);
         `CHK(conn, {k[1] ? 6'h3F : 6'h00, k[0] ? 6'h3F : 6'h00})
         `CHK(code[0], 12'hFFF)
      end
      wr(8'h0C, 16'hF5A5);
      repeat (2) @(posedge clk_sys);
      `CHK(conn, 12'h5A5)
      rd(8'h2A, 16'h0FFF);
      host.bank(1'b0, 1'b1);
      repeat (2) @(posedge clk_sys);
      `CHK(conn, 12'h580)
      host.bank(1'b1, 1'b1);
      wr(8'h0C, 16'hFFFF);
      // Temperature results and limit flags
      temp_done(10'h324, 10'h029);
      rd(8'h0E, 16'h0324);
      rd(8'h0F, 16'h0029);
      `CHK(under, 2'b00)
      wr(8'h57, 16'h0325);
      repeat (3) @(posedge clk_sys);
      `CHK(under, 2'b01)
      wr(8'h58, 16'h0028);
      repeat (3) @(posedge clk_sys);
      `CHK(over, 2'b10)
      wr(8'h03, 16'h0080);
      temp_done(10'h000, 10'h000);
      rd(8'h0E, 16'h0324);
      // Sixteen cycle mean at the fastest averaging rate
      host.change_rate(16'h0015, 16'h0081);
      for (int n = 0; n < 15; n++)
         temp_done(n[0] ? 10'h3FF : 10'h000, 10'h064);
      rd(8'h0E, 16'h0324);
      temp_done(10'h3FF, 10'h064);
      rd(8'h0E, 16'h03FF);
      rd(8'h0F, 16'h0064);
      // Each rate code with averaging requested, one cycle each
      prev = 10'h3FF;
      for (int c = 0; c < 10; c++)
      begin
         host.change_rate({11'h000, 1'b1, 4'(c)}, 16'h0081);
         temp_done(10'(c + 20), 10'h000);
         if (c > 5)
            prev = 10'(c + 20);
         rd(8'h0E, {6'h00, prev});
      end
      host.change_rate(16'h0000, 16'h0081);
      temp_done(10'h1F4, 10'h001);
      rd(8'h0E, 16'h01F4);
      // Voltage results at both ends of the table
      @(posedge clk_sys);
      adc <= '{code: 10'h3FF, chan: 4'hF, valid: 1'b1};
      @(posedge clk_sys);
      adc <= '{code: 10'h200, chan: 4'h0, valid: 1'b1};
      @(posedge clk_sys);
      adc <= '{code: 10'h1FF, chan: 4'h5, valid: 1'b0};
      rd(8'h29, 16'h03FF);
      rd(8'h1A, 16'h0200);
      rd(8'h1F, 16'h0000);
      report_and_stop();
   end
endmodule
